// ===== verilog/ep0_pkg.sv
// shared constants for the endpoint-zero buffer ends
package ep0_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 64;
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam int ADDR_W = 32;
  localparam int SETUP_LEN = 8;
  localparam logic [3:0] SETUP_FULL = 4'h8;
  // ----------------------------------------------------------------
  // device register addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] OUT_FIFO_ADDR = 32'h0ffffe80;
  localparam logic [31:0] OUT_LEN_ADDR = 32'hfffffe81;
  localparam logic [31:0] IN_FIFO_ADDR = 32'h0ffffe83;
  localparam logic [31:0] SETUP_ADDR = 32'h0ffffe88;
  localparam logic [31:0] STATUS_ADDR = 32'h0ffffe89;
  localparam logic [31:0] NAK_ADDR = 32'h0ffffe8a;
  localparam logic [31:0] DEND_ADDR = 32'h0ffffe8b;
  localparam logic [31:0] CLEAR_ADDR = 32'h0ffffe8c;
  // ----------------------------------------------------------------
  // device field positions and reset values
  // ----------------------------------------------------------------
  localparam int ST_OUT_RECEIVED = 0;
  localparam int ST_PROTECT = 1;
  localparam int ST_DECODE = 2;
  localparam int ST_OUT_UNREAD = 3;
  localparam int ST_IN_PRESENT = 4;
  localparam int NAK_OUT = 0;
  localparam int NAK_IN = 1;
  localparam int DEND_BIT = 0;
  localparam int CLR_OUT = 0;
  localparam int CLR_IN = 1;
  localparam int REQ_TYPE_HI = 6;
  localparam int REQ_TYPE_LO = 5;
  localparam logic [1:0] REQ_STANDARD = 2'h0;
  localparam logic [7:0] LEN_RESET = 8'h00;
  localparam logic [7:0] IN_READ_VALUE = 8'h00;
  // ----------------------------------------------------------------
  // link token kinds
  // ----------------------------------------------------------------
  localparam logic [1:0] TOK_SETUP = 2'h0;
  localparam logic [1:0] TOK_OUT = 2'h1;
  localparam logic [1:0] TOK_IN = 2'h2;
  // ----------------------------------------------------------------
  // host controller registers
  // ----------------------------------------------------------------
  localparam logic [3:0] H_TX_ADDR = 4'h0;
  localparam logic [3:0] H_RX_ADDR = 4'h1;
  localparam logic [3:0] H_CMD_ADDR = 4'h2;
  localparam logic [3:0] H_STATUS_ADDR = 4'h3;
  localparam int CMD_KIND_LO = 0;
  localparam int CMD_KIND_HI = 1;
  localparam int CMD_BAD = 2;
  localparam int CMD_ACK = 3;
  localparam logic [3:0] LISTEN_LIMIT = 4'hf;
endpackage : ep0_pkg

// ===== verilog/ep0_link_if.sv
// packet-level link between the usb host end and the endpoint-zero end
`timescale 1ns/10ps
`default_nettype none
interface ep0_link_if;
  // host to device
  logic tok_valid;
  logic [1:0] tok_kind;
  logic dat_valid;
  logic [7:0] dat;
  logic pkt_end;
  logic pkt_good;
  logic hs_ack;
  // device to host
  logic nak;
  logic in_valid;
  logic [7:0] in_data;
  logic in_end;

  modport dev (
    input tok_valid, tok_kind, dat_valid, dat, pkt_end, pkt_good, hs_ack,
    output nak, in_valid, in_data, in_end
  );
  modport host (
    output tok_valid, tok_kind, dat_valid, dat, pkt_end, pkt_good, hs_ack,
    input nak, in_valid, in_data, in_end
  );
endinterface : ep0_link_if
`default_nettype wire

// ===== verilog/ep0_byte_fifo.sv
// byte fifo with clear, used for both directions of endpoint zero
`timescale 1ns/10ps
`default_nettype none
module ep0_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clear_in,
  input wire logic push_in,
  input wire logic [WIDTH-1:0] data_in,
  input wire logic pop_in,
  output logic [WIDTH-1:0] head_out,
  output logic [$clog2(DEPTH+1)-1:0] count_out,
  output logic full_out,
  output logic empty_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;

  // ----------------------------------------------------------------
  // flags and qualified strobes
  // ----------------------------------------------------------------
  // pointers wrap by overflow, so depth must be a power of two
  wire logic do_push = push_in && !full_out && !clear_in;
  wire logic do_pop = pop_in && !empty_out && !clear_in;
  assign full_out = (count == CW'(DEPTH));
  assign empty_out = (count == '0);
  assign head_out = mem[rd_ptr];
  assign count_out = count;

  // storage needs no reset, the count guards it
  always_ff @(posedge clk_in)
  begin
    if (do_push)
      mem[wr_ptr] <= data_in;
  end

  // pointers and fill count
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || clear_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= do_push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= do_pop ? rd_ptr + 1'b1 : rd_ptr;
      count <= count + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule : ep0_byte_fifo
`default_nettype wire

// ===== verilog/ep0_dev_end.sv
// endpoint-zero out fifo, setup buffer and in fifo of the usb function
// Function
// - 64-byte read-only fifo holds control out data
// - good out packet: flag, length, interrupt request
// - length tracks bytes; bad packet zeroes it
// - each out fifo read decrements length
// - length zero clears out nak, ready again
// - unread status drops once all bytes read
// - firmware reads all bytes or clears fifo
// - new setup token clears out fifo
// - good setup: store, protect, decode, interrupt (decode flag set here only for non-standard request types)
// - firmware reads setup in eight-byte groups
// - setup read pointer survives usb bus reset
// - setup always accepted; bad one raises nothing
// - setup under eight bytes keeps old packet
// - firmware checks protect flag before fifo use
// - 64-byte write-only in fifo reads zero
// - in data sent only when in nak set
// - host ack clears in nak bit
// - data end: short or zero-length packet
// - setup token clears unfinished in fifo
// - status stage without ack clears in fifo
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module ep0_dev_end (
  input wire logic clk_in,
  input wire logic resetn_in,
  ep0_link_if.dev link,
  input wire logic [ep0_pkg::ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic ep0_interrupt_request_out
);
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_SETUP = 4'b0010,
    RX_OUT = 4'b0100,
    RX_DROP = 4'b1000
  } ep0_rx_e;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_WAIT = 3'b100
  } ep0_tx_e;
  localparam int CW = ep0_pkg::CNT_W;

  ep0_rx_e rx_state;
  ep0_rx_e next_rx;
  ep0_tx_e tx_state;
  ep0_tx_e next_tx;
  logic [7:0] out_len;
  logic out_nak;
  logic in_nak;
  logic dend;
  logic flag_rcv;
  logic flag_setup_protect_flag;
  logic flag_dec;
  logic [3:0] stage_cnt;
  logic [2:0] set_rd_ptr;
  logic [7:0] stage [ep0_pkg::SETUP_LEN];
  logic [7:0] setup_buf [ep0_pkg::SETUP_LEN];
  logic [7:0] out_head;
  logic [7:0] in_head;
  logic [CW-1:0] in_count;
  logic out_empty;
  logic in_empty;

  // ----------------------------------------------------------------
  // register and token decode
  // ----------------------------------------------------------------
  wire logic hit_out_rd = rd_in && addr_in == ep0_pkg::OUT_FIFO_ADDR;
  wire logic hit_set_rd = rd_in && addr_in == ep0_pkg::SETUP_ADDR;
  wire logic hit_in_wr = wr_in && addr_in == ep0_pkg::IN_FIFO_ADDR;
  wire logic hit_stat_wr = wr_in && addr_in == ep0_pkg::STATUS_ADDR;
  wire logic hit_nak_wr = wr_in && addr_in == ep0_pkg::NAK_ADDR;
  wire logic hit_dend_wr = wr_in && addr_in == ep0_pkg::DEND_ADDR;
  wire logic hit_clr_wr = wr_in && addr_in == ep0_pkg::CLEAR_ADDR;
  wire logic tok_setup = link.tok_valid && link.tok_kind == ep0_pkg::TOK_SETUP;
  wire logic tok_out = link.tok_valid && link.tok_kind == ep0_pkg::TOK_OUT;
  wire logic tok_in = link.tok_valid && link.tok_kind == ep0_pkg::TOK_IN;
  wire logic clr_out_fw = hit_clr_wr && wdata_in[ep0_pkg::CLR_OUT];
  wire logic clr_in_fw = hit_clr_wr && wdata_in[ep0_pkg::CLR_IN];
  wire logic set_dend_fw = hit_dend_wr && wdata_in[ep0_pkg::DEND_BIT];

  // ----------------------------------------------------------------
  // out data stage
  // ----------------------------------------------------------------
  // writes to the out fifo address have no decode and are dropped
  wire logic out_push = rx_state == RX_OUT && link.dat_valid;
  wire logic out_bad = rx_state == RX_OUT && link.pkt_end && !link.pkt_good;
  wire logic out_good = rx_state == RX_OUT && link.pkt_end && link.pkt_good
    && out_len != ep0_pkg::LEN_RESET;
  wire logic len_drain = hit_out_rd && out_len == 8'h01;
  // a bad packet or a new setup empties the fifo at once
  wire logic out_clear = tok_setup || clr_out_fw || out_bad;
  wire logic [7:0] next_out_len =
    out_clear ? ep0_pkg::LEN_RESET :
    out_push ? out_len + 8'h01 :
    (hit_out_rd && out_len != ep0_pkg::LEN_RESET) ? out_len - 8'h01 :
    out_len;
  // a finished packet beats a simultaneous firmware clear
  wire logic next_out_nak =
    out_good ? 1'b1 :
    (len_drain || out_clear) ? 1'b0 :
    hit_nak_wr ? wdata_in[ep0_pkg::NAK_OUT] : out_nak;

  ep0_byte_fifo #(
    .WIDTH(ep0_pkg::BYTE_W),
    .DEPTH(ep0_pkg::FIFO_DEPTH)
  ) u_out_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clear_in(out_clear),
    .push_in(out_push),
    .data_in(link.dat),
    .pop_in(hit_out_rd),
    .head_out(out_head),
    .count_out(),
    .full_out(),
    .empty_out(out_empty)
  );

  // ----------------------------------------------------------------
  // setup stage
  // ----------------------------------------------------------------
  wire logic stage_wr = rx_state == RX_SETUP && link.dat_valid
    && stage_cnt != ep0_pkg::SETUP_FULL;
  // short packets never reach the copy, so old contents stay
  wire logic setup_done = rx_state == RX_SETUP && link.pkt_end
    && stage_cnt == ep0_pkg::SETUP_FULL;
  wire logic setup_good = setup_done && link.pkt_good;
  wire logic fw_request = stage[0][ep0_pkg::REQ_TYPE_HI:ep0_pkg::REQ_TYPE_LO]
    != ep0_pkg::REQ_STANDARD;

  // staging keeps the live buffer intact until the packet length is known
  generate
    for (genvar i = 0; i < ep0_pkg::SETUP_LEN; i++)
    begin : g_setup
      always_ff @(posedge clk_in)
      begin
        if (!resetn_in)
        begin
          stage[i] <= 8'h00;
          setup_buf[i] <= 8'h00;
        end
        else
        begin
          if (stage_wr && stage_cnt[2:0] == 3'(i))
            stage[i] <= link.dat;
          // a bad full-length packet still overwrites the old one
          if (setup_done)
            setup_buf[i] <= stage[i];
        end
      end
    end
  endgenerate

  // staging count and firmware read pointer
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      stage_cnt <= 4'h0;
      set_rd_ptr <= 3'h0;
    end
    else
    begin
      stage_cnt <= tok_setup ? 4'h0 : stage_cnt + 4'(stage_wr);
      // only the chip reset clears it; eight reads wrap it home
      set_rd_ptr <= set_rd_ptr + 3'(hit_set_rd);
    end
  end

  // ----------------------------------------------------------------
  // status flags, set wins over a write-one clear
  // ----------------------------------------------------------------
  wire logic next_rcv = out_good
    || (flag_rcv && !(hit_stat_wr && wdata_in[ep0_pkg::ST_OUT_RECEIVED]));
  // firmware polls this before touching the fifos
  wire logic next_setup_protect_flag = setup_good
    || (flag_setup_protect_flag && !(hit_stat_wr && wdata_in[ep0_pkg::ST_PROTECT]));
  wire logic next_dec = (setup_good && fw_request)
    || (flag_dec && !(hit_stat_wr && wdata_in[ep0_pkg::ST_DECODE]));

  // ----------------------------------------------------------------
  // in data stage
  // ----------------------------------------------------------------
  wire logic in_push = hit_in_wr;
  wire logic in_go = tx_state == TX_IDLE && tok_in && in_nak;
  // first byte leaves with the token answer, so the host sees it one cycle on
  wire logic in_pop = tx_state == TX_SEND || (in_go && !in_empty);
  wire logic in_clear = clr_in_fw
    || (tok_setup && (!in_empty || in_nak || tx_state != TX_IDLE))
    || (tok_out && (!in_empty || in_nak || tx_state != TX_IDLE));
  wire logic ack_seen = tx_state == TX_WAIT && link.hs_ack;
  wire logic last_byte = in_pop && in_count == CW'(1);
  // data end arms the in nak bit so the packet goes out as is
  wire logic next_in_nak =
    (tok_setup || tok_out) ? 1'b0 :
    hit_nak_wr ? wdata_in[ep0_pkg::NAK_IN] :
    set_dend_fw ? 1'b1 :
    ack_seen ? 1'b0 : in_nak;
  wire logic next_dend =
    (in_clear || ack_seen) ? 1'b0 :
    hit_dend_wr ? wdata_in[ep0_pkg::DEND_BIT] : dend;

  ep0_byte_fifo #(
    .WIDTH(ep0_pkg::BYTE_W),
    .DEPTH(ep0_pkg::FIFO_DEPTH)
  ) u_in_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clear_in(in_clear),
    .push_in(in_push),
    .data_in(wdata_in),
    .pop_in(in_pop),
    .head_out(in_head),
    .count_out(in_count),
    .full_out(),
    .empty_out(in_empty)
  );

  // transmit sequencing
  always_comb
  begin
    next_tx = tx_state;
    unique case (tx_state)
      TX_IDLE:
        if (in_go)
          next_tx = (in_empty || last_byte) ? TX_WAIT : TX_SEND;
      TX_SEND:
        if (last_byte || in_empty)
          next_tx = TX_WAIT;
      TX_WAIT:
        if (link.hs_ack || link.tok_valid)
          next_tx = TX_IDLE;
    endcase
  end

  // receive mode follows each token; a busy fifo turns out into a drop
  assign next_rx = tok_setup ? RX_SETUP :
    tok_out ? (out_nak ? RX_DROP : RX_OUT) :
    (tok_in || link.pkt_end) ? RX_IDLE : rx_state;

  // ----------------------------------------------------------------
  // register read path
  // ----------------------------------------------------------------
  wire logic [7:0] status_byte = {3'h0, !in_empty || dend,
    !out_empty, flag_dec, flag_setup_protect_flag, flag_rcv};
  wire logic [7:0] rd_value =
    addr_in == ep0_pkg::OUT_FIFO_ADDR ? out_head :
    addr_in == ep0_pkg::OUT_LEN_ADDR ? out_len :
    addr_in == ep0_pkg::SETUP_ADDR ? setup_buf[set_rd_ptr] :
    addr_in == ep0_pkg::STATUS_ADDR ? status_byte :
    addr_in == ep0_pkg::NAK_ADDR ? {6'h00, in_nak, out_nak} :
    addr_in == ep0_pkg::DEND_ADDR ? {7'h00, dend} :
    ep0_pkg::IN_READ_VALUE;

  // ----------------------------------------------------------------
  // state and output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      rx_state <= RX_IDLE;
      tx_state <= TX_IDLE;
      out_len <= ep0_pkg::LEN_RESET;
      out_nak <= 1'b0;
      in_nak <= 1'b0;
      dend <= 1'b0;
      flag_rcv <= 1'b0;
      flag_setup_protect_flag <= 1'b0;
      flag_dec <= 1'b0;
      rdata_out <= 8'h00;
      ep0_interrupt_request_out <= 1'b0;
      link.nak <= 1'b0;
      link.in_valid <= 1'b0;
      link.in_data <= 8'h00;
      link.in_end <= 1'b0;
    end
    else
    begin
      rx_state <= next_rx;
      tx_state <= next_tx;
      out_len <= next_out_len;
      out_nak <= next_out_nak;
      in_nak <= next_in_nak;
      dend <= next_dend;
      flag_rcv <= next_rcv;
      flag_setup_protect_flag <= next_setup_protect_flag;
      flag_dec <= next_dec;
      rdata_out <= rd_in ? rd_value : 8'h00;
      ep0_interrupt_request_out <= flag_rcv || flag_setup_protect_flag || flag_dec;
      link.nak <= (tok_in && !in_nak)
        || (rx_state == RX_DROP && link.pkt_end);
      link.in_valid <= in_pop && !in_empty;
      link.in_data <= in_head;
      link.in_end <= last_byte || (in_go && in_empty);
    end
  end
endmodule : ep0_dev_end
`default_nettype wire

// ===== verilog/ep0_host_end.sv
// usb host side of the endpoint-zero link, driven through a small command port
`timescale 1ns/10ps
`default_nettype none
module ep0_host_end (
  input wire logic clk_in,
  input wire logic resetn_in,
  ep0_link_if.host link,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_DATA = 3'b010,
    H_LISTEN = 3'b100
  } ep0_host_e;
  localparam int CW = ep0_pkg::CNT_W;

  ep0_host_e state;
  ep0_host_e next_state;
  logic cmd_bad;
  logic cmd_ack;
  logic saw_nak;
  logic timed_out;
  logic [3:0] wait_cnt;
  logic [7:0] tx_head;
  logic [7:0] rx_head;
  logic tx_empty;
  logic tx_full;
  logic rx_empty;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // commands while busy are dropped
  wire logic hit_cmd = wr_in && addr_in == ep0_pkg::H_CMD_ADDR && state == H_IDLE;
  wire logic hit_tx = wr_in && addr_in == ep0_pkg::H_TX_ADDR;
  wire logic hit_rx = rd_in && addr_in == ep0_pkg::H_RX_ADDR;
  wire logic [1:0] cmd_kind = wdata_in[ep0_pkg::CMD_KIND_HI:ep0_pkg::CMD_KIND_LO];
  wire logic listen_done = link.in_end || link.nak
    || wait_cnt == ep0_pkg::LISTEN_LIMIT;
  wire logic [7:0] status_byte = {3'h0, timed_out, saw_nak, !rx_empty, tx_full,
    state != H_IDLE};
  wire logic [7:0] rd_value = addr_in == ep0_pkg::H_RX_ADDR ? rx_head :
    addr_in == ep0_pkg::H_STATUS_ADDR ? status_byte : 8'h00;

  // outgoing payload for setup and out packets
  ep0_byte_fifo #(
    .WIDTH(ep0_pkg::BYTE_W),
    .DEPTH(ep0_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clear_in(1'b0),
    .push_in(hit_tx),
    .data_in(wdata_in),
    .pop_in(state == H_DATA),
    .head_out(tx_head),
    .count_out(),
    .full_out(tx_full),
    .empty_out(tx_empty)
  );

  // in payload; a new command throws the last one away
  ep0_byte_fifo #(
    .WIDTH(ep0_pkg::BYTE_W),
    .DEPTH(ep0_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clear_in(hit_cmd),
    .push_in(state == H_LISTEN && link.in_valid),
    .data_in(link.in_data),
    .pop_in(hit_rx),
    .head_out(rx_head),
    .count_out(),
    .full_out(),
    .empty_out(rx_empty)
  );

  // transaction sequencing
  always_comb
  begin
    next_state = state;
    unique case (state)
      H_IDLE:
        if (hit_cmd)
          next_state = cmd_kind == ep0_pkg::TOK_IN ? H_LISTEN : H_DATA;
      H_DATA:
        if (tx_empty)
          next_state = H_IDLE;
      H_LISTEN:
        if (listen_done)
          next_state = H_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state and link registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state <= H_IDLE;
      cmd_bad <= 1'b0;
      cmd_ack <= 1'b0;
      saw_nak <= 1'b0;
      timed_out <= 1'b0;
      wait_cnt <= 4'h0;
      rdata_out <= 8'h00;
      link.tok_valid <= 1'b0;
      link.tok_kind <= ep0_pkg::TOK_SETUP;
      link.dat_valid <= 1'b0;
      link.dat <= 8'h00;
      link.pkt_end <= 1'b0;
      link.pkt_good <= 1'b0;
      link.hs_ack <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cmd_bad <= hit_cmd ? wdata_in[ep0_pkg::CMD_BAD] : cmd_bad;
      cmd_ack <= hit_cmd ? wdata_in[ep0_pkg::CMD_ACK] : cmd_ack;
      saw_nak <= !hit_cmd && (saw_nak || link.nak);
      timed_out <= !hit_cmd && (timed_out
        || (state == H_LISTEN && wait_cnt == ep0_pkg::LISTEN_LIMIT));
      // a silent device must not hang the host
      wait_cnt <= (state == H_LISTEN && !link.in_valid) ? wait_cnt + 4'h1 : 4'h0;
      rdata_out <= rd_in ? rd_value : 8'h00;
      link.tok_valid <= hit_cmd;
      link.tok_kind <= hit_cmd ? cmd_kind : link.tok_kind;
      link.dat_valid <= state == H_DATA && !tx_empty;
      link.dat <= tx_head;
      link.pkt_end <= state == H_DATA && tx_empty;
      link.pkt_good <= !cmd_bad;
      link.hs_ack <= state == H_LISTEN && link.in_end && cmd_ack;
    end
  end
endmodule : ep0_host_end
`default_nettype wire

// ===== tb/ep0_link_monitor.sv
// link checks between the host end and the device end of endpoint zero
`timescale 1ns/10ps
`default_nettype none
module ep0_link_monitor (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic tok_valid,
  input wire logic [1:0] tok_kind,
  input wire logic pkt_end,
  input wire logic hs_ack,
  input wire logic nak,
  input wire logic in_valid,
  input wire logic in_end
);
  // ----------------------------------------------------------------
  // link assertions
  // ----------------------------------------------------------------
  // in token decode, shared by several checks
  wire logic in_tok = tok_valid && (tok_kind == ep0_pkg::TOK_IN);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  a_in_token_answer: assert property (in_tok |=> nak || in_valid || in_end)
    else $error("in token left unanswered");
  a_nak_no_data: assert property (nak |-> !in_valid && !in_end)
    else $error("data sent beside a nak");
  a_nak_has_cause: assert property (nak |-> $past(in_tok) || $past(pkt_end))
    else $error("nak without a token");
  a_nak_one_cycle: assert property (nak |=> !nak)
    else $error("nak longer than one cycle");
  a_in_burst_start: assert property (in_valid |-> $past(in_valid) || $past(in_tok))
    else $error("in byte outside a packet");
  a_end_closes_packet: assert property (in_end |=> !in_valid && !in_end)
    else $error("in traffic after packet end");
  a_ack_after_end: assert property (hs_ack |-> $past(in_end))
    else $error("ack without a finished in packet");
  a_token_one_cycle: assert property (tok_valid |=> !tok_valid)
    else $error("token longer than one cycle");
  // main traffic kinds
  c_in_data: cover property (in_tok ##1 in_valid);
  c_in_refused: cover property (in_tok ##1 nak);
  c_in_acked: cover property (in_end ##1 hs_ack);
endmodule : ep0_link_monitor
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench joining host end and device end of endpoint zero
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [31:0] d_addr = 32'h0;
  logic [7:0] d_wd = 8'h00;
  logic d_wr = 1'b0;
  logic d_rd = 1'b0;
  logic [7:0] d_q;
  logic irq;
  logic [3:0] h_addr = 4'h0;
  logic [7:0] h_wd = 8'h00;
  logic h_wr = 1'b0;
  logic h_rd = 1'b0;
  logic [7:0] h_q;
  logic [7:0] q;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  ep0_link_if link ();
  ep0_dev_end i_ep0_dev_end (.clk_in(clk_in), .resetn_in(resetn_in), .link(link),
    .addr_in(d_addr), .wdata_in(d_wd), .wr_in(d_wr), .rd_in(d_rd), .rdata_out(d_q),
    .ep0_interrupt_request_out(irq));
  ep0_host_end i_ep0_host_end (.clk_in(clk_in), .resetn_in(resetn_in), .link(link),
    .addr_in(h_addr), .wdata_in(h_wd), .wr_in(h_wr), .rd_in(h_rd), .rdata_out(h_q));
  ep0_link_monitor i_ep0_link_monitor (.clk_in(clk_in), .resetn_in(resetn_in),
    .tok_valid(link.tok_valid), .tok_kind(link.tok_kind), .pkt_end(link.pkt_end),
    .hs_ack(link.hs_ack), .nak(link.nak), .in_valid(link.in_valid), .in_end(link.in_end));
  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  // free-running 20 MHz clock
  initial
  begin
    forever #25 clk_in = ~clk_in;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end
  // one strobe on either port; read data lands in q one cycle later
  task automatic bus(input bit h, input bit w, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_in);
    d_addr <= a;
    h_addr <= a[3:0];
    d_wd <= d;
    h_wd <= d;
    d_wr <= w & !h;
    d_rd <= !w & !h;
    h_wr <= w & h;
    h_rd <= !w & h;
    @(posedge clk_in);
    {d_wr, d_rd, h_wr, h_rd} <= 4'h0;
    #1;
    q = h ? h_q : d_q;
  endtask : bus
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rdck(input bit h, input logic [31:0] a, input logic [7:0] e, input string s);
    bus(h, 1'b0, a, 8'h00);
    chk(s, q, e);
  endtask : rdck
  // polls host busy, unbounded; the guard above catches a stuck host
  task automatic send(input logic [7:0] cmd, input int n, input logic [7:0] b0);
    for (int i = 0; i < n; i++)
      bus(1'b1, 1'b1, ep0_pkg::H_TX_ADDR, b0 + 8'(i));
    bus(1'b1, 1'b1, ep0_pkg::H_CMD_ADDR, cmd);
    q = 8'h01;
    while (q[0] !== 1'b0)
      bus(1'b1, 1'b0, ep0_pkg::H_STATUS_ADDR, 8'h00);
    repeat (3) @(posedge clk_in);
  endtask : send
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_setup();
    send(8'h00, 8, 8'h40);
    rdck(0, ep0_pkg::STATUS_ADDR, 8'h06, "status");
    chk("irq", {7'h0, irq}, 8'h01);
    send(8'h00, 4, 8'h00);
    for (int i = 0; i < 8; i++)
      rdck(0, ep0_pkg::SETUP_ADDR, 8'h40 + 8'(i), "setup byte");
    bus(0, 1, ep0_pkg::STATUS_ADDR, 8'h07);
    $display("setup test done");
  endtask : t_setup
  task automatic t_out();
    send(8'h01, 3, 8'h10);
    bus(0, 1, ep0_pkg::OUT_FIFO_ADDR, 8'h99);
    rdck(0, ep0_pkg::STATUS_ADDR, 8'h09, "status");
    for (int i = 0; i < 3; i++)
    begin
      rdck(0, ep0_pkg::OUT_LEN_ADDR, 8'(3 - i), "out length");
      rdck(0, ep0_pkg::OUT_FIFO_ADDR, 8'h10 + 8'(i), "out byte");
    end
    rdck(0, ep0_pkg::NAK_ADDR, 8'h00, "nak control");
    rdck(0, ep0_pkg::STATUS_ADDR, 8'h01, "status");
    bus(0, 1, ep0_pkg::STATUS_ADDR, 8'h07);
    send(8'h05, 2, 8'h20);
    rdck(0, ep0_pkg::OUT_LEN_ADDR, 8'h00, "bad length");
    rdck(0, ep0_pkg::STATUS_ADDR, 8'h00, "status");
    chk("irq", {7'h0, irq}, 8'h00);
    $display("out test done");
  endtask : t_out
  task automatic t_in();
    bus(0, 1, ep0_pkg::IN_FIFO_ADDR, 8'h5a);
    bus(0, 1, ep0_pkg::IN_FIFO_ADDR, 8'h5b);
    rdck(0, ep0_pkg::IN_FIFO_ADDR, 8'h00, "in read");
    rdck(0, 32'h0ffffe8f, 8'h00, "unmapped");
    send(8'h0a, 0, 8'h00);
    rdck(1, ep0_pkg::H_STATUS_ADDR, 8'h08, "host status");
    bus(0, 1, ep0_pkg::DEND_ADDR, 8'h01);
    send(8'h0a, 0, 8'h00);
    rdck(1, ep0_pkg::H_RX_ADDR, 8'h5a, "in byte");
    rdck(1, ep0_pkg::H_RX_ADDR, 8'h5b, "in byte");
    rdck(0, ep0_pkg::NAK_ADDR, 8'h00, "nak control");
    bus(0, 1, ep0_pkg::DEND_ADDR, 8'h01);
    send(8'h0a, 0, 8'h00);
    rdck(0, ep0_pkg::STATUS_ADDR, 8'h00, "status");
    $display("in test done");
  endtask : t_in
  task automatic t_clear();
    send(8'h01, 2, 8'h30);
    // unread out data keeps the fifo closed, a second packet is refused
    send(8'h01, 1, 8'h31);
    rdck(1, ep0_pkg::H_STATUS_ADDR, 8'h08, "busy nak");
    rdck(0, ep0_pkg::OUT_LEN_ADDR, 8'h02, "held length");
    bus(0, 1, ep0_pkg::STATUS_ADDR, 8'h07);
    bus(0, 1, ep0_pkg::IN_FIFO_ADDR, 8'h77);
    send(8'h00, 8, 8'h00);
    rdck(0, ep0_pkg::OUT_LEN_ADDR, 8'h00, "out length");
    rdck(0, ep0_pkg::STATUS_ADDR, 8'h02, "status");
    bus(0, 1, ep0_pkg::IN_FIFO_ADDR, 8'h78);
    bus(0, 1, ep0_pkg::DEND_ADDR, 8'h01);
    send(8'h02, 0, 8'h00);
    send(8'h01, 0, 8'h00);
    bus(0, 0, ep0_pkg::NAK_ADDR, 8'h00);
    chk("in nak", q & 8'h02, 8'h00);
    bus(0, 0, ep0_pkg::STATUS_ADDR, 8'h00);
    chk("in present", q & 8'h10, 8'h00);
    $display("clear test done");
  endtask : t_clear
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    rdck(0, ep0_pkg::OUT_LEN_ADDR, ep0_pkg::LEN_RESET, "length reset");
    t_setup();
    t_out();
    t_in();
    t_clear();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
